// >>> logic/ssf_pkg.sv
// Constants and register map for the supply and transceiver status flag bank
// What this block does
// (RL1) Aux supply low latches after 100 us persistence; clears when gone and read.
// (RL2) Aux supply overcurrent latches after 100 us; clears when gone and read.
// (RL3) Transceiver supply overheat sets on sensor; clears when cool and read.
// (RL4) Transceiver supply undervoltage latches after 100 us; clears when gone and read.
// (RL5) Transceiver supply overcurrent latches after 100 us; clears when gone and read.
// (RL6) Sense input low latches after 100 us; clears when gone and read.
// (RL7) Battery input undervoltage latches after 100 us; clears when gone and read.
// (RL8) Core supply overcurrent in run mode latches after 100 us; clears when gone and read.
// (RL9) Core overcurrent in low-power supply-on mode latches separately after 100 us.
// (RL10) Core overheat sets on thermal shutdown; clears after recovery and read.
// (RL11) Short reset pulse under 100 ms sets flag; clears after pulse ends and read.
// (RL12) Battery lost sets below fail level; clears when above and read.
// (RL13) Driver state reads live: 1 enabled, 0 disabled.
// (RL14) Driver disabled by receive-only command or stuck dominant transmit failure.
// (RL15) Receiver state reads live; disabled by command such as sleep.
// (RL16) Wake receiver state reads live; host controlled, enabled after reset.
// (RL17) Reading transceiver status never alters the live state flags.
// (RL18) Wake-source flag sets on bus wake, clears on read.
// (RL19) Persistence filter restarts whenever the condition drops early.
// (RL20) Clear on read only takes effect if the condition is absent at the read.
package ssf_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 125;
  localparam int FILT_TIME_US   = 100;
  localparam int FILT_CYCLES    = FILT_TIME_US * CLK_MHZ;
  localparam int SHORT_RST_MS   = 100;
  localparam int SHORT_RST_CYC  = SHORT_RST_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Register map (word offsets)
  // ****************************************
  localparam logic [3:0] REG_SUPPLY = 4'h0;
  localparam logic [3:0] REG_XCVR   = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;

  // Supply flag bit positions
  localparam int B_AUX_LOW  = 0;
  localparam int B_AUX_OC   = 1;
  localparam int B_XS_HOT   = 2;
  localparam int B_XS_UV    = 3;
  localparam int B_XS_OC    = 4;
  localparam int B_SENSE    = 5;
  localparam int B_BAT_UV   = 6;
  localparam int B_CORE_OCR = 7;
  localparam int B_CORE_OCL = 8;
  localparam int B_CORE_HOT = 9;
  localparam int B_SHORT_RST = 10;
  localparam int B_BAT_LOST = 11;
  localparam int N_SUP      = 12;

  // Transceiver status bit positions
  localparam int X_DRV  = 0;
  localparam int X_RCV  = 1;
  localparam int X_WAKE = 2;
  localparam int X_WSRC = 3;

  // Control bit positions and reset value
  localparam int C_RXONLY = 0;
  localparam int C_SLEEP  = 1;
  localparam int C_WAKEEN = 2;
  localparam logic [2:0] CTRL_RST = 3'h4;

endpackage

// >>> logic/ssf_flags.sv
// Status flag bank for the supply monitors and transceiver state
`timescale 1ns/1ns
module ssf_flags #(
  parameter int FILT_CYC  = ssf_pkg::FILT_CYCLES,   // Persistence time in cycles
  parameter int SHORT_CYC = ssf_pkg::SHORT_RST_CYC  // Short reset pulse limit
) (
  input  wire logic        core_clk,          // 125 MHz clock
  input  wire logic        rst_b,             // Sync reset, active low
  input  wire logic [3:0]  addr,              // Register word address
  input  wire logic [31:0] wdata,             // Write data
  input  wire logic        wr,                // Write strobe
  input  wire logic        rd,                // Read strobe
  output logic      [31:0] rdata,             // Read data, cycle after rd
  input  wire logic        aux_uv,            // Aux output under threshold
  input  wire logic        aux_oc,            // Aux current over limit
  input  wire logic        xs_hot,            // Transceiver supply sensor hot
  input  wire logic        xs_uv,             // Transceiver supply under threshold
  input  wire logic        xs_oc,             // Transceiver supply over current
  input  wire logic        sense_low,         // Sense pin under threshold
  input  wire logic        bat_low,           // Battery pin under threshold
  input  wire logic        core_oc,           // Core current over run limit
  input  wire logic        core_oc_lp,        // Core current over low-power limit
  input  wire logic        run_mode,          // Device in run mode
  input  wire logic        lp_on_mode,        // Low-power mode, core kept on
  input  wire logic        core_off_hot,      // Core switched off for heat
  input  wire logic        reset_pin_b,       // Reset pin level, active low
  input  wire logic        bat_fail,          // Battery under fail level
  input  wire logic        txd_stuck,         // Stuck dominant transmit failure
  input  wire logic        bus_wake,          // Bus wake detected, pulse
  output logic             drv_en,            // Transceiver driver enable
  output logic             rcv_en,            // Receiver enable
  output logic             wake_rcv_en        // Wake receiver enable
);

  localparam int CW = $clog2((SHORT_CYC > FILT_CYC ? SHORT_CYC : FILT_CYC) + 1);

  // ****************************************
  // Condition vector and persistence
  // ****************************************
  logic [ssf_pkg::N_SUP-1:0] cond;
  logic [ssf_pkg::N_SUP-1:0] filt;
  logic [ssf_pkg::N_SUP-1:0] flag_q;
  logic [CW-1:0]             cnt_q [ssf_pkg::N_SUP];
  logic [CW-1:0]             rst_cnt_q;
  logic                      rst_pin_q;
  logic                      short_ev;
  logic                      rd_sup;
  logic                      rd_x;
  logic [2:0]                ctrl_q;
  logic                      wsrc_q;

  // ****************************************
  // Helpers
  // ****************************************
  // Filter expiry test, shared by every timed flag and its checks except a_aux_low_set
  function automatic logic filt_done(input logic [CW-1:0] c);
    return c == CW'(FILT_CYC);
  endfunction

  // Strobe and address decode, shared by the read and write paths
  function automatic logic addr_hit(input logic s, input logic [3:0] a, input logic [3:0] w);
    return s && (a == w);
  endfunction

  // Raw conditions; short reset uses its own detector
  always_comb begin
    cond = '0;
    cond[ssf_pkg::B_AUX_LOW]   = aux_uv;
    cond[ssf_pkg::B_AUX_OC]    = aux_oc;
    cond[ssf_pkg::B_XS_HOT]    = xs_hot;
    cond[ssf_pkg::B_XS_UV]     = xs_uv;
    cond[ssf_pkg::B_XS_OC]     = xs_oc;
    cond[ssf_pkg::B_SENSE]     = sense_low;
    cond[ssf_pkg::B_BAT_UV]    = bat_low;
    cond[ssf_pkg::B_CORE_OCR]  = core_oc && run_mode;      // RL8
    cond[ssf_pkg::B_CORE_OCL]  = core_oc_lp && lp_on_mode; // RL9
    cond[ssf_pkg::B_CORE_HOT]  = core_off_hot;
    cond[ssf_pkg::B_SHORT_RST] = !reset_pin_b;
    cond[ssf_pkg::B_BAT_LOST]  = bat_fail;
  end

  // Filter counters restart when a condition drops before expiry
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < ssf_pkg::N_SUP; i++) begin
      if (!rst_b || !cond[i]) begin
        cnt_q[i] <= '0; // RL19
      end else if (!filt_done(cnt_q[i])) begin
        cnt_q[i] <= cnt_q[i] + CW'(1);
      end
    end
  end

  // Timed flags need full persistence; event flags set at once
  always_comb begin
    filt = cond;
    filt[ssf_pkg::B_AUX_LOW]  = filt_done(cnt_q[ssf_pkg::B_AUX_LOW]);  // RL1
    filt[ssf_pkg::B_AUX_OC]   = filt_done(cnt_q[ssf_pkg::B_AUX_OC]);   // RL2
    filt[ssf_pkg::B_XS_UV]    = filt_done(cnt_q[ssf_pkg::B_XS_UV]);    // RL4
    filt[ssf_pkg::B_XS_OC]    = filt_done(cnt_q[ssf_pkg::B_XS_OC]);    // RL5
    filt[ssf_pkg::B_SENSE]    = filt_done(cnt_q[ssf_pkg::B_SENSE]);    // RL6
    filt[ssf_pkg::B_BAT_UV]   = filt_done(cnt_q[ssf_pkg::B_BAT_UV]);   // RL7
    filt[ssf_pkg::B_CORE_OCR] = filt_done(cnt_q[ssf_pkg::B_CORE_OCR]); // RL8
    filt[ssf_pkg::B_CORE_OCL] = filt_done(cnt_q[ssf_pkg::B_CORE_OCL]); // RL9
    filt[ssf_pkg::B_SHORT_RST] = short_ev;
  end

  // ****************************************
  // Short reset pulse detector
  // ****************************************
  // Long pulses saturate the counter and are not reported
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rst_pin_q <= 1'b1;
      rst_cnt_q <= '0;
    end else begin
      rst_pin_q <= reset_pin_b;
      if (reset_pin_b) begin
        rst_cnt_q <= '0;
      end else if (rst_cnt_q != CW'(SHORT_CYC)) begin
        rst_cnt_q <= rst_cnt_q + CW'(1);
      end
    end
  end

  // Rising edge of the pin with a pulse shorter than the limit
  assign short_ev = reset_pin_b && !rst_pin_q && (rst_cnt_q < CW'(SHORT_CYC)); // RL11

  // ****************************************
  // Latched supply flags
  // ****************************************
  assign rd_sup = addr_hit(rd, addr, ssf_pkg::REG_SUPPLY);
  assign rd_x   = addr_hit(rd, addr, ssf_pkg::REG_XCVR);

  // Set wins over clear; read clears only if the cause is gone.
  // The short reset cause is the pin being low.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flag_q <= '0;
    end else begin
      flag_q <= filt | (flag_q & ~({ssf_pkg::N_SUP{rd_sup}} & ~cond)); // RL20 RL3 RL10 RL12
    end
  end

  // ****************************************
  // Transceiver control and live state
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_q <= ssf_pkg::CTRL_RST; // RL16
    end else if (addr_hit(wr, addr, ssf_pkg::REG_CTRL)) begin
      ctrl_q <= wdata[2:0];
    end
  end

  // Enables register the command and failure state; reads never touch them
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      drv_en      <= 1'b0;
      rcv_en      <= 1'b0;
      wake_rcv_en <= 1'b0;
    end else begin
      drv_en      <= !ctrl_q[ssf_pkg::C_RXONLY] && !ctrl_q[ssf_pkg::C_SLEEP]
                     && !txd_stuck;                   // RL14
      rcv_en      <= !ctrl_q[ssf_pkg::C_SLEEP];      // RL15
      wake_rcv_en <= ctrl_q[ssf_pkg::C_WAKEEN];      // RL16 RL17
    end
  end

  // Wake source flag: set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wsrc_q <= 1'b0;
    end else begin
      wsrc_q <= bus_wake || (wsrc_q && !rd_x); // RL18
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (rd_sup) begin
      rdata <= {{(32 - ssf_pkg::N_SUP){1'b0}}, flag_q};
    end else if (rd_x) begin
      rdata <= {28'h0, wsrc_q, wake_rcv_en, rcv_en, drv_en}; // RL13 RL17
    end else if (addr_hit(rd, addr, ssf_pkg::REG_CTRL)) begin
      rdata <= {29'h0, ctrl_q};
    end else begin
      rdata <= '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_aux_low_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL1
    (cnt_q[ssf_pkg::B_AUX_LOW] == CW'(FILT_CYC)) |=> flag_q[ssf_pkg::B_AUX_LOW])
    else $error("aux low flag not set after filter");

  a_filt_restart: assert property (@(posedge core_clk) disable iff (!rst_b) // RL19
    !aux_oc |=> cnt_q[ssf_pkg::B_AUX_OC] == '0)
    else $error("filter did not restart");

  a_clear_held: assert property (@(posedge core_clk) disable iff (!rst_b) // RL20
    (rd_sup && flag_q[ssf_pkg::B_XS_HOT] && xs_hot) |=> flag_q[ssf_pkg::B_XS_HOT])
    else $error("flag cleared while cause present");

  a_clear_read: assert property (@(posedge core_clk) disable iff (!rst_b) // RL12
    (rd_sup && !bat_fail) |=> !flag_q[ssf_pkg::B_BAT_LOST])
    else $error("battery lost not cleared");

  a_core_hot: assert property (@(posedge core_clk) disable iff (!rst_b) // RL10
    core_off_hot |=> flag_q[ssf_pkg::B_CORE_HOT])
    else $error("core overheat not set");

  a_run_gate: assert property (@(posedge core_clk) disable iff (!rst_b) // RL8
    !run_mode |=> cnt_q[ssf_pkg::B_CORE_OCR] == '0)
    else $error("run overcurrent counted outside run");

  a_drv_stuck: assert property (@(posedge core_clk) disable iff (!rst_b) // RL14
    txd_stuck |=> !drv_en)
    else $error("driver enabled with stuck transmit");

  a_wake_src: assert property (@(posedge core_clk) disable iff (!rst_b) // RL18
    bus_wake |=> wsrc_q)
    else $error("wake source flag lost");

  a_wake_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL18
    (rd_x && !bus_wake) |=> !wsrc_q)
    else $error("wake source flag not cleared by read");

  a_rdata_x: assert property (@(posedge core_clk) disable iff (!rst_b) // RL13
    rd_x |=> rdata[0] == $past(drv_en))
    else $error("driver state misreported");

  // Timed flags set once their filter has expired
  a_aux_oc_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL2
    filt_done(cnt_q[ssf_pkg::B_AUX_OC]) |=> flag_q[ssf_pkg::B_AUX_OC])
    else $error("aux overcurrent flag not set after filter");

  a_xs_uv_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL4
    filt_done(cnt_q[ssf_pkg::B_XS_UV]) |=> flag_q[ssf_pkg::B_XS_UV])
    else $error("transceiver undervoltage flag not set");

  a_xs_oc_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL5
    filt_done(cnt_q[ssf_pkg::B_XS_OC]) |=> flag_q[ssf_pkg::B_XS_OC])
    else $error("transceiver overcurrent flag not set");

  a_sense_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL6
    filt_done(cnt_q[ssf_pkg::B_SENSE]) |=> flag_q[ssf_pkg::B_SENSE])
    else $error("sense low flag not set");

  a_bat_uv_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL7
    filt_done(cnt_q[ssf_pkg::B_BAT_UV]) |=> flag_q[ssf_pkg::B_BAT_UV])
    else $error("battery undervoltage flag not set");

  a_core_run_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL8
    filt_done(cnt_q[ssf_pkg::B_CORE_OCR]) |=> flag_q[ssf_pkg::B_CORE_OCR])
    else $error("run overcurrent flag not set");

  a_core_lp_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL9
    filt_done(cnt_q[ssf_pkg::B_CORE_OCL]) |=> flag_q[ssf_pkg::B_CORE_OCL])
    else $error("low-power overcurrent flag not set");

  a_no_early_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL19
    (!filt_done(cnt_q[ssf_pkg::B_AUX_LOW]) && !flag_q[ssf_pkg::B_AUX_LOW])
    |=> !flag_q[ssf_pkg::B_AUX_LOW])
    else $error("aux low flag set before filter expiry");

  // Event flags set in the cycle after their cause
  a_xs_hot_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL3
    xs_hot |=> flag_q[ssf_pkg::B_XS_HOT])
    else $error("transceiver overheat flag not set");

  a_bat_lost_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL12
    bat_fail |=> flag_q[ssf_pkg::B_BAT_LOST])
    else $error("battery lost flag not set");

  a_short_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RL11
    short_ev |=> flag_q[ssf_pkg::B_SHORT_RST])
    else $error("short reset flag not set");

  a_short_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // RL11
    (!flag_q[ssf_pkg::B_SHORT_RST] && !short_ev) |=> !flag_q[ssf_pkg::B_SHORT_RST])
    else $error("short reset flag set without short pulse");

  // Read clears only flags whose cause is already gone
  a_aux_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL1
    (rd_sup && !aux_uv && cnt_q[ssf_pkg::B_AUX_LOW] == '0) |=> !flag_q[ssf_pkg::B_AUX_LOW])
    else $error("aux low flag not cleared by read");

  a_xs_hot_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL3
    (rd_sup && !xs_hot) |=> !flag_q[ssf_pkg::B_XS_HOT])
    else $error("transceiver overheat flag not cleared");

  a_core_hot_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL10
    (rd_sup && !core_off_hot) |=> !flag_q[ssf_pkg::B_CORE_HOT])
    else $error("core overheat flag not cleared");

  a_short_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL11
    (rd_sup && reset_pin_b && !short_ev) |=> !flag_q[ssf_pkg::B_SHORT_RST])
    else $error("short reset flag not cleared");

  a_held_oc: assert property (@(posedge core_clk) disable iff (!rst_b) // RL20
    (rd_sup && flag_q[ssf_pkg::B_XS_OC] && xs_oc) |=> flag_q[ssf_pkg::B_XS_OC])
    else $error("overcurrent flag cleared while cause present");

  // Low-power overcurrent only counts in its own mode
  a_lp_gate: assert property (@(posedge core_clk) disable iff (!rst_b) // RL9
    !lp_on_mode |=> cnt_q[ssf_pkg::B_CORE_OCL] == '0)
    else $error("low-power overcurrent counted outside mode");

  // Live enables follow control and failure one cycle later
  a_drv_rxonly: assert property (@(posedge core_clk) disable iff (!rst_b) // RL14
    ctrl_q[ssf_pkg::C_RXONLY] |=> !drv_en)
    else $error("driver enabled in receive-only mode");

  a_drv_on: assert property (@(posedge core_clk) disable iff (!rst_b) // RL14
    (!ctrl_q[ssf_pkg::C_RXONLY] && !ctrl_q[ssf_pkg::C_SLEEP] && !txd_stuck) |=> drv_en)
    else $error("driver not enabled");

  a_rcv_sleep: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
    ctrl_q[ssf_pkg::C_SLEEP] |=> !rcv_en)
    else $error("receiver enabled in sleep");

  a_rcv_on: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
    !ctrl_q[ssf_pkg::C_SLEEP] |=> rcv_en)
    else $error("receiver not enabled");

  a_wake_follow: assert property (@(posedge core_clk) disable iff (!rst_b) // RL16
    ctrl_q[ssf_pkg::C_WAKEEN] |=> wake_rcv_en)
    else $error("wake receiver not enabled");

  a_wake_off: assert property (@(posedge core_clk) disable iff (!rst_b) // RL16
    !ctrl_q[ssf_pkg::C_WAKEEN] |=> !wake_rcv_en)
    else $error("wake receiver not disabled");

  a_live_stable: assert property (@(posedge core_clk) disable iff (!rst_b) // RL17
    (rd_x && $stable(ctrl_q) && $stable(txd_stuck)) |=> $stable(drv_en) && $stable(rcv_en)
    && $stable(wake_rcv_en))
    else $error("live state changed by status read");

  a_rdata_rcv: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
    rd_x |=> rdata[ssf_pkg::X_RCV] == $past(rcv_en))
    else $error("receiver state misreported");

  a_rdata_wake: assert property (@(posedge core_clk) disable iff (!rst_b) // RL16
    rd_x |=> rdata[ssf_pkg::X_WAKE] == $past(wake_rcv_en))
    else $error("wake receiver state misreported");

endmodule

// >>> tb/ssf_host.sv
// Host model that reads and writes the flag bank registers
`timescale 1ns/1ns
module ssf_host (
  input  wire logic        core_clk, // Bus clock
  output logic      [3:0]  addr,     // Word address
  output logic      [31:0] wdata,    // Write data
  output logic             wr,       // Write strobe
  output logic             rd,       // Read strobe
  input  wire logic [31:0] rdata     // Read data
);
  // Bus idle from time zero
  initial begin
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Single-cycle write, slave never stalls
  task automatic write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

// >>> tb/ssf_flags_tb.sv
// Self-checking bench for the supply and transceiver status flag bank
`timescale 1ns/1ns
module ssf_flags_tb;
  localparam int FC = 20; // Short persistence keeps the run brief
  localparam int SC = 50;
  localparam logic [13:0] MSK [12] = '{14'h1, 14'h2, 14'h4, 14'h8, 14'h10, 14'h20, 14'h40,
    14'h880, 14'h1100, 14'h200, 14'h0, 14'h400};
  localparam logic [3:0] SUP = ssf_pkg::REG_SUPPLY;
  localparam logic [3:0] XC = ssf_pkg::REG_XCVR;
  localparam logic [3:0] CT = ssf_pkg::REG_CTRL;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [13:0] cond = 14'h0; // Monitor levels, one bit each
  logic        reset_pin_b = 1'b1;
  logic        bus_wake = 1'b0;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic        drv_en;
  logic        rcv_en;
  logic        wake_rcv_en;
  int          mismatches = 0;
  int          samples_checked = 0;
  // Clock
  always #4 core_clk = ~core_clk;
  ssf_host ssf_host_i (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  ssf_flags #(.FILT_CYC(FC), .SHORT_CYC(SC)) ssf_flags_i (.core_clk(core_clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .aux_uv(cond[0]),
    .aux_oc(cond[1]), .xs_hot(cond[2]), .xs_uv(cond[3]), .xs_oc(cond[4]),
    .sense_low(cond[5]), .bat_low(cond[6]), .core_oc(cond[7]), .core_oc_lp(cond[8]),
    .core_off_hot(cond[9]), .bat_fail(cond[10]), .run_mode(cond[11]),
    .lp_on_mode(cond[12]), .txd_stuck(cond[13]), .reset_pin_b(reset_pin_b),
    .bus_wake(bus_wake), .drv_en(drv_en), .rcv_en(rcv_en), .wake_rcv_en(wake_rcv_en));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string w);
    logic [31:0] d;
    ssf_host_i.read(a, d);
    check(w, d, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic setc(input logic [13:0] m);
    @(posedge core_clk);
    cond <= m;
  endtask
  task automatic pulse(input int n);
    @(posedge core_clk);
    reset_pin_b <= 1'b0;
    wt(n);
    reset_pin_b <= 1'b1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    ssf_host_i.write(SUP, 32'hffff);
    rd_chk(SUP, 32'h0, "supply");
    rd_chk(XC, 32'h7, "xcvr");
    rd_chk(CT, 32'h4, "ctrl");
    rd_chk(4'hf, 32'h0, "unmapped");
  endtask
  // Event flags skip the broken-condition pass since they have no filter
  task automatic t_latched;
    logic [31:0] b;
    for (int i = 0; i < 12; i++) begin
      b = 32'h1 << i;
      if (i != 10) begin
        if (i != 2 && i != 9 && i != 11) begin
          setc(MSK[i]);
          wt(FC - 3);
          setc(14'h0);
          setc(MSK[i]);
          wt(FC - 3);
          setc(14'h0);
          wt(3);
          rd_chk(SUP, 32'h0, "broken");
        end
        setc(MSK[i]);
        wt(FC + 5);
        rd_chk(SUP, b, "held");
        rd_chk(SUP, b, "held reread");
        setc(14'h0);
        wt(3);
        rd_chk(SUP, b, "gone");
        rd_chk(SUP, 32'h0, "cleared");
      end
    end
    setc(14'h180);
    wt(FC + 5);
    setc(14'h0);
    wt(2);
    rd_chk(SUP, 32'h0, "wrong mode");
  endtask
  task automatic t_short;
    pulse(10);
    wt(3);
    rd_chk(SUP, 32'h400, "short");
    rd_chk(SUP, 32'h0, "short clr");
    pulse(SC + 10);
    wt(3);
    rd_chk(SUP, 32'h0, "long");
  endtask
  task automatic t_xcvr;
    ssf_host_i.write(CT, 32'h5);
    wt(2);
    rd_chk(XC, 32'h6, "rx only");
    rd_chk(XC, 32'h6, "reread");
    check("drv pin", {31'h0, drv_en}, 32'h0);
    ssf_host_i.write(CT, 32'h0);
    wt(2);
    rd_chk(XC, 32'h3, "wake off");
    check("wake pin", {31'h0, wake_rcv_en}, 32'h0);
    ssf_host_i.write(CT, 32'h6);
    wt(2);
    check("rcv pin", {31'h0, rcv_en}, 32'h0);
    ssf_host_i.write(CT, 32'h4);
    @(posedge core_clk);
    bus_wake <= 1'b1;
    @(posedge core_clk);
    bus_wake <= 1'b0;
    wt(2);
    rd_chk(XC, 32'hf, "wake src");
    rd_chk(XC, 32'h7, "wake clr");
    setc(14'h2000);
    wt(3);
    rd_chk(XC, 32'h6, "stuck");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    wt(20);
    rst_b <= 1'b1;
    wt(2);
    t_reset;
    t_latched;
    t_short;
    t_xcvr;
    results;
  end
  // Watchdog, well past the fewer than a thousand cycles the run needs
  initial begin
    wt(20000);
    mismatches++;
    results;
  end
endmodule
